/* mcm_defines.svh */
`ifndef MCM_DEFINES_SVH
`define MCM_DEFINES_SVH
// csr indices on the device carrier (per processor unless noted)
`define MCM_REG_CMD      4'h0
`define MCM_REG_SRC_PF   4'h1
`define MCM_REG_DST_PF   4'h2
`define MCM_REG_SRC_OFF  4'h3
`define MCM_REG_DST_OFF  4'h4
`define MCM_REG_STATUS   4'h5
`define MCM_REG_CTX      4'h6
`define MCM_REG_RX_CFG   4'h8
`define MCM_REG_RX_AVAIL 4'h9
`define MCM_REG_RX_OCC   4'hA
// field positions, lsb numbering (bit 0 of the big-endian view is [63])
`define MCM_CMD_READY    40
`define MCM_CMD_SIDX     39:38
`define MCM_CMD_ABORT_EN 37
`define MCM_CMD_PURGE    36
`define MCM_CMD_SRC_TBL  35
`define MCM_CMD_DST_TBL  34
`define MCM_CMD_MSG      33
`define MCM_CMD_ZERO     32
`define MCM_CMD_IN_IE    29
`define MCM_CMD_CMP_IE   28:27
`define MCM_CMD_INUM     26:22
`define MCM_CMD_LEN      21:0
`define MCM_PF_FRAME     39:12
`define MCM_OFF_FIELD    21:0
`define MCM_CTX_ARMED    0
`define MCM_CTX_TRIG     1
`define MCM_RX_SIZE      1:0
`define MCM_RX_OFF       24:5
`define MCM_ST_VALID     63
`define MCM_ST_OVF       62
// completion classes and error codes
`define MCM_CLS_OK       4'h0
`define MCM_CLS_MOVER    4'h1
`define MCM_CLS_ALLOC    4'h6
`define MCM_CODE_PURGE   5'h00
`define MCM_CODE_NOMEM   5'h02
// reception area geometry, in 32-byte lines, and status queue depth in entries
`define MCM_RX_LOG2_MIN  5'd10
`define MCM_RX_LOG2_STEP 5'd3
`define MCM_QUEUE_DEPTH  2'd3
// wishbone register byte offsets of the controller
`define MCM_WB_CTRL      5'h00
`define MCM_WB_WLO       5'h04
`define MCM_WB_WHI       5'h08
`define MCM_WB_RLO       5'h0C
`define MCM_WB_RHI       5'h10
`define MCM_WB_IRQ       5'h14
`endif

/* mcm_pkg.sv */
package mcm_pkg;
  typedef enum logic [1:0] {
    MCM_IDLE = 2'b00,
    MCM_TAKE = 2'b01,
    MCM_RUN  = 2'b10,
    MCM_POST = 2'b11
  } mcm_state_e;
  typedef logic [61:0] mcm_entry_t;
endpackage

/* mcm_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mcm_if;
  logic        csr_req;
  logic        csr_we;
  logic        csr_cpu;
  logic [3:0]  csr_addr;
  logic [63:0] csr_wdata;
  logic        csr_ack;
  logic [63:0] csr_rdata;
  logic        irq_valid;
  logic        irq_cpu;
  logic [5:0]  irq_num;
  modport device (input csr_req, csr_we, csr_cpu, csr_addr, csr_wdata,
                  output csr_ack, csr_rdata, irq_valid, irq_cpu, irq_num);
  modport host (output csr_req, csr_we, csr_cpu, csr_addr, csr_wdata,
                input csr_ack, csr_rdata, irq_valid, irq_cpu, irq_num);
endinterface
`default_nettype wire

/* mcm_status_queue.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcm_defines.svh"
module mcm_status_queue
  import mcm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       push,
  input  wire mcm_entry_t push_entry,
  input  wire logic       pop,
  output mcm_entry_t      head,
  output logic            valid,
  output logic            overflow
);
  mcm_entry_t mem_q [0:2];
  logic [1:0] cnt_q;
  logic       ovf_q;
  logic       do_pop;
  logic       do_push;
  logic [1:0] wr_idx;

  assign do_pop  = pop && (cnt_q != 2'd0);
  assign do_push = push && ((cnt_q != `MCM_QUEUE_DEPTH) || do_pop);
  assign wr_idx  = cnt_q - {1'b0, do_pop};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 2'd0;
    else
      cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
  end

  // oldest entry sits at index 0; a read shifts the rest down
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (do_push && (wr_idx == 2'(i)))
        mem_q[i] <= push_entry;
      else if (do_pop)
        mem_q[i] <= mem_q[(i == 2) ? 2 : i + 1];
    end
  end

  // a loss in the same cycle as the read keeps the flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ovf_q <= 1'b0;
    else if (push && !do_push)
      ovf_q <= 1'b1;
    else if (pop)
      ovf_q <= 1'b0;
  end

  assign head     = mem_q[0];
  assign valid    = (cnt_q != 2'd0);
  assign overflow = ovf_q;
endmodule // mcm_status_queue
`default_nettype wire

/* mcm_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcm_defines.svh"
module mcm_device
  import mcm_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  mcm_if.device            LINK,
  input  wire logic        PURGE_SEEN,
  output logic             OP_START,
  output logic             OP_MSG,
  output logic             OP_ZERO,
  output logic [22:0]      OP_BYTES,
  output logic [27:0]      OP_SRC_FRAME,
  output logic             OP_SRC_TBL,
  output logic [9:0]       OP_SRC_IDX,
  output logic [21:0]      OP_SRC_OFF,
  output logic [27:0]      OP_DST_FRAME,
  output logic             OP_DST_TBL,
  output logic [9:0]       OP_DST_IDX,
  output logic [21:0]      OP_DST_OFF,
  output logic [19:0]      OP_MSG_LINE,
  input  wire logic        OP_DONE,
  input  wire logic [3:0]  OP_CLASS,
  input  wire logic [1:0]  OP_CTRL,
  input  wire logic [3:0]  OP_PORT,
  input  wire logic [4:0]  OP_CODE,
  input  wire logic [21:0] OP_REMAIN
);
  logic [63:0] cmd_q   [0:1];
  logic [63:0] spf_q   [0:1];
  logic [63:0] dpf_q   [0:1];
  logic [63:0] soff_q  [0:1];
  logic [63:0] doff_q  [0:1];
  logic [1:0]  ctx_q   [0:1];
  logic [1:0]  rx_size_q;
  logic [19:0] avail_q;
  logic [19:0] occ_q;
  logic        ack_q;
  logic [63:0] rdata_q;
  logic        irq_q;
  logic        irq_cpu_q;
  logic [5:0]  irq_num_q;
  mcm_state_e  state_q;
  logic        cur_q;
  mcm_entry_t  entry_q;
  logic        acc;
  logic        wr;
  logic [1:0]  clr_ready;
  logic [1:0]  q_push;
  logic [1:0]  q_pop;
  logic [1:0]  q_valid;
  logic [1:0]  q_ovf;
  mcm_entry_t  q_head [0:1];
  logic [63:0] cmd_c;
  logic [17:0] msg_lines;
  logic [20:0] area_lines;
  logic [20:0] wrap_mask;
  logic [20:0] used_lines;
  logic        alloc_ok;

  // table mode splits the field, else it is a plain page offset
  function automatic logic [31:0] mcm_xlate(input logic tbl, input logic [21:0] off);
    mcm_xlate = tbl ? {off[21:12], 10'h0, off[11:0]}
                    : {10'h0, off};
  endfunction

  assign acc = LINK.csr_req && !ack_q;
  assign wr  = acc && LINK.csr_we;

  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_cpu
      logic sel;
      logic guard_ok;
      logic guarded;
      assign sel      = wr && (LINK.csr_cpu == 1'(c));
      assign guard_ok = !cmd_q[c][`MCM_CMD_READY] && ctx_q[c][`MCM_CTX_ARMED];
      assign guarded  = sel && (LINK.csr_addr inside {`MCM_REG_CMD, `MCM_REG_SRC_PF,
                        `MCM_REG_DST_PF, `MCM_REG_SRC_OFF, `MCM_REG_DST_OFF});
      assign q_pop[c] = acc && !LINK.csr_we && (LINK.csr_cpu == 1'(c))
                        && (LINK.csr_addr == `MCM_REG_STATUS);

      always_ff @(posedge CLK_SYS or negedge RESETN)
      begin
        if (!RESETN)
        begin
          cmd_q[c]  <= 64'h0000_0000_0000_0000;
          spf_q[c]  <= 64'h0000_0000_0000_0000;
          dpf_q[c]  <= 64'h0000_0000_0000_0000;
          soff_q[c] <= 64'h0000_0000_0000_0000;
          doff_q[c] <= 64'h0000_0000_0000_0000;
        end
        else
        begin
          if (guarded && guard_ok)
          begin
            unique case (LINK.csr_addr)
              `MCM_REG_CMD:     cmd_q[c]  <= LINK.csr_wdata;
              `MCM_REG_SRC_PF:  spf_q[c]  <= LINK.csr_wdata;
              `MCM_REG_DST_PF:  dpf_q[c]  <= LINK.csr_wdata;
              `MCM_REG_SRC_OFF: soff_q[c] <= LINK.csr_wdata;
              `MCM_REG_DST_OFF: doff_q[c] <= LINK.csr_wdata;
              default: ;
            endcase
          end
          if (clr_ready[c])
            cmd_q[c][`MCM_CMD_READY] <= 1'b0;
          if (PURGE_SEEN)
            cmd_q[c][`MCM_CMD_PURGE] <= 1'b1;
        end
      end

      // a guarded write keeps the arm only if triggered: next triggered = armed
      always_ff @(posedge CLK_SYS or negedge RESETN)
      begin
        if (!RESETN)
          ctx_q[c] <= 2'b00;
        else if (sel && (LINK.csr_addr == `MCM_REG_CTX))
          ctx_q[c] <= LINK.csr_wdata[1:0];
        else if (guarded)
          ctx_q[c] <= {ctx_q[c][`MCM_CTX_ARMED],
                       ctx_q[c][`MCM_CTX_ARMED] & ctx_q[c][`MCM_CTX_TRIG]};
      end

      mcm_status_queue u_queue (
        .clk        (CLK_SYS),
        .rst_n      (RESETN),
        .push       (q_push[c]),
        .push_entry (entry_q),
        .pop        (q_pop[c]),
        .head       (q_head[c]),
        .valid      (q_valid[c]),
        .overflow   (q_ovf[c])
      );
    end
  endgenerate

  // reception area, shared by both processors
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_size_q <= 2'b00;
      avail_q   <= 20'h0_0000;
      occ_q     <= 20'h0_0000;
    end
    else
    begin
      if (wr && (LINK.csr_addr == `MCM_REG_RX_CFG))
        rx_size_q <= LINK.csr_wdata[`MCM_RX_SIZE];
      if (wr && (LINK.csr_addr == `MCM_REG_RX_OCC))
        occ_q <= LINK.csr_wdata[`MCM_RX_OFF];
      if (state_q == MCM_TAKE && cmd_c[`MCM_CMD_MSG] && alloc_ok)
        avail_q <= 20'((21'(avail_q) + 21'(msg_lines)) & wrap_mask);
      else if (wr && (LINK.csr_addr == `MCM_REG_RX_AVAIL))
        avail_q <= LINK.csr_wdata[`MCM_RX_OFF];
    end
  end

  // one bit above the offset tells full from empty
  assign cmd_c      = cmd_q[cur_q];
  assign msg_lines  = {1'b0, cmd_c[21:5]} + 18'h0_0001;
  assign area_lines = 21'h00_0001 << (`MCM_RX_LOG2_MIN + rx_size_q * `MCM_RX_LOG2_STEP);
  assign wrap_mask  = (area_lines << 1) - 21'h00_0001;
  assign used_lines = (21'(avail_q) - 21'(occ_q)) & wrap_mask;
  assign alloc_ok   = 21'(msg_lines) <= (area_lines - used_lines);

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      ack_q <= acc;
      if (acc && !LINK.csr_we)
      begin
        unique case (LINK.csr_addr)
          `MCM_REG_CMD:      rdata_q <= cmd_q[LINK.csr_cpu];
          `MCM_REG_SRC_PF:   rdata_q <= spf_q[LINK.csr_cpu];
          `MCM_REG_DST_PF:   rdata_q <= dpf_q[LINK.csr_cpu];
          `MCM_REG_SRC_OFF:  rdata_q <= soff_q[LINK.csr_cpu];
          `MCM_REG_DST_OFF:  rdata_q <= doff_q[LINK.csr_cpu];
          `MCM_REG_STATUS:   rdata_q <= {q_valid[LINK.csr_cpu], q_ovf[LINK.csr_cpu],
                                         q_head[LINK.csr_cpu]};
          `MCM_REG_CTX:      rdata_q <= {62'h0, ctx_q[LINK.csr_cpu]};
          `MCM_REG_RX_CFG:   rdata_q <= {62'h0, rx_size_q};
          `MCM_REG_RX_AVAIL: rdata_q <= {39'h0, avail_q, 5'h00};
          `MCM_REG_RX_OCC:   rdata_q <= {39'h0, occ_q, 5'h00};
          default:           rdata_q <= 64'h0000_0000_0000_0000;
        endcase
      end
    end
  end

  assign clr_ready = (state_q == MCM_TAKE) ? (cur_q ? 2'b10 : 2'b01) : 2'b00;
  assign q_push    = (state_q == MCM_POST) ? (cur_q ? 2'b10 : 2'b01) : 2'b00;

  // mover sequencer: processor 0 wins a tie
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q      <= MCM_IDLE;
      cur_q        <= 1'b0;
      entry_q      <= '0;
      OP_START     <= 1'b0;
      OP_MSG       <= 1'b0;
      OP_ZERO      <= 1'b0;
      OP_BYTES     <= 23'h00_0000;
      OP_SRC_FRAME <= 28'h000_0000;
      OP_SRC_TBL   <= 1'b0;
      {OP_SRC_IDX, OP_SRC_OFF} <= 32'h0000_0000;
      OP_DST_FRAME <= 28'h000_0000;
      OP_DST_TBL   <= 1'b0;
      {OP_DST_IDX, OP_DST_OFF} <= 32'h0000_0000;
      OP_MSG_LINE  <= 20'h0_0000;
    end
    else
    begin
      OP_START <= 1'b0;
      unique case (state_q)
        MCM_IDLE:
        begin
          if (cmd_q[0][`MCM_CMD_READY] || cmd_q[1][`MCM_CMD_READY])
          begin
            cur_q   <= !cmd_q[0][`MCM_CMD_READY];
            state_q <= MCM_TAKE;
          end
        end
        MCM_TAKE:
        begin
          entry_q <= {cmd_c[`MCM_CMD_SIDX], 60'h0};
          if (cmd_c[`MCM_CMD_ABORT_EN] && cmd_c[`MCM_CMD_PURGE])
          begin
            entry_q[59:0] <= {`MCM_CLS_MOVER, 6'h00, `MCM_CODE_PURGE, 23'h0,
                              cmd_c[`MCM_CMD_LEN]};
            state_q       <= MCM_POST;
          end
          else if (cmd_c[`MCM_CMD_MSG] && !alloc_ok)
          begin
            entry_q[59:0] <= {`MCM_CLS_ALLOC, 6'h00, `MCM_CODE_NOMEM, 45'h0};
            state_q       <= MCM_POST;
          end
          else
          begin
            OP_START     <= 1'b1;
            OP_MSG       <= cmd_c[`MCM_CMD_MSG];
            OP_ZERO      <= cmd_c[`MCM_CMD_ZERO];
            OP_BYTES     <= cmd_c[`MCM_CMD_MSG] ? {msg_lines, 5'h00}
                                                : {1'b0, cmd_c[`MCM_CMD_LEN]} + 23'h00_0001;
            OP_SRC_FRAME <= spf_q[cur_q][`MCM_PF_FRAME];
            OP_SRC_TBL   <= cmd_c[`MCM_CMD_SRC_TBL];
            {OP_SRC_IDX, OP_SRC_OFF} <= mcm_xlate(cmd_c[`MCM_CMD_SRC_TBL],
                                                 soff_q[cur_q][`MCM_OFF_FIELD]);
            OP_DST_FRAME <= dpf_q[cur_q][`MCM_PF_FRAME];
            OP_DST_TBL   <= cmd_c[`MCM_CMD_DST_TBL];
            {OP_DST_IDX, OP_DST_OFF} <= mcm_xlate(cmd_c[`MCM_CMD_DST_TBL],
                                                 doff_q[cur_q][`MCM_OFF_FIELD]);
            OP_MSG_LINE  <= avail_q;
            state_q      <= MCM_RUN;
          end
        end
        MCM_RUN:
        begin
          if (OP_DONE)
          begin
            entry_q[59:0] <= {OP_CLASS, OP_CTRL, OP_PORT, OP_CODE, 23'h0,
                              (OP_CLASS == `MCM_CLS_OK) ? 22'h3F_FFFF : OP_REMAIN};
            state_q       <= MCM_POST;
          end
        end
        MCM_POST:
          state_q <= MCM_IDLE;
      endcase
    end
  end

  // interrupt number: five high bits from the command, lsb marks the event
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      irq_q     <= 1'b0;
      irq_cpu_q <= 1'b0;
      irq_num_q <= 6'h00;
    end
    else
    begin
      irq_q     <= 1'b0;
      irq_cpu_q <= cur_q;
      if (state_q == MCM_TAKE)
      begin
        irq_q     <= cmd_c[`MCM_CMD_IN_IE];
        irq_num_q <= {cmd_c[`MCM_CMD_INUM], 1'b0};
      end
      else if (state_q == MCM_POST)
      begin
        irq_q     <= (cmd_c[`MCM_CMD_CMP_IE] == 2'b01) || (cmd_c[`MCM_CMD_CMP_IE] == 2'b11)
                     || ((cmd_c[`MCM_CMD_CMP_IE] == 2'b10) && (entry_q[59:56] != 4'h0));
        irq_num_q <= {cmd_c[`MCM_CMD_INUM], 1'b1};
      end
    end
  end

  assign LINK.csr_ack   = ack_q;
  assign LINK.csr_rdata = rdata_q;
  assign LINK.irq_valid = irq_q;
  assign LINK.irq_cpu   = irq_cpu_q;
  assign LINK.irq_num   = irq_num_q;
endmodule // mcm_device
`default_nettype wire

/* mcm_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mcm_defines.svh"
module mcm_host
  import mcm_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  mcm_if.host              LINK,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [4:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O
);
  logic        ack_q;
  logic        req_q;
  logic        we_q;
  logic        cpu_q;
  logic [3:0]  addr_q;
  logic [63:0] wdata_q;
  logic [63:0] rdata_q;
  logic [7:0]  irq_q;
  logic        acc;
  logic        wr;

  function automatic logic [31:0] mcm_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
      mcm_merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  assign acc = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr  = acc && WB_WE_I;

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      wdata_q <= 64'h0000_0000_0000_0000;
    else if (wr && (WB_ADR_I == `MCM_WB_WLO))
      wdata_q[31:0] <= mcm_merge(wdata_q[31:0], WB_DAT_I, WB_SEL_I);
    else if (wr && (WB_ADR_I == `MCM_WB_WHI))
      wdata_q[63:32] <= mcm_merge(wdata_q[63:32], WB_DAT_I, WB_SEL_I);
  end

  // csr access runs until the device acks; a new order while busy is dropped
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      cpu_q   <= 1'b0;
      addr_q  <= 4'h0;
      rdata_q <= 64'h0000_0000_0000_0000;
    end
    else if (req_q)
    begin
      if (LINK.csr_ack)
      begin
        req_q <= 1'b0;
        if (!we_q)
          rdata_q <= LINK.csr_rdata;
      end
    end
    else if (wr && (WB_ADR_I == `MCM_WB_CTRL) && WB_SEL_I[0])
    begin
      req_q  <= 1'b1;
      we_q   <= WB_DAT_I[0];
      cpu_q  <= WB_DAT_I[1];
      addr_q <= WB_DAT_I[7:4];
    end
  end

  // last interrupt seen; a new one wins over the clear
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      irq_q <= 8'h00;
    else if (LINK.irq_valid)
      irq_q <= {1'b1, LINK.irq_cpu, LINK.irq_num};
    else if (wr && (WB_ADR_I == `MCM_WB_IRQ) && WB_SEL_I[0] && WB_DAT_I[7])
      irq_q[7] <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_q    <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= acc;
      if (acc)
      begin
        unique case (WB_ADR_I)
          `MCM_WB_CTRL: WB_DAT_O <= {23'h0, req_q, addr_q, 2'b00, cpu_q, we_q};
          `MCM_WB_WLO:  WB_DAT_O <= wdata_q[31:0];
          `MCM_WB_WHI:  WB_DAT_O <= wdata_q[63:32];
          `MCM_WB_RLO:  WB_DAT_O <= rdata_q[31:0];
          `MCM_WB_RHI:  WB_DAT_O <= rdata_q[63:32];
          `MCM_WB_IRQ:  WB_DAT_O <= {24'h0, irq_q};
          default:      WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK_O       = ack_q;
  assign LINK.csr_req   = req_q;
  assign LINK.csr_we    = we_q;
  assign LINK.csr_cpu   = cpu_q;
  assign LINK.csr_addr  = addr_q;
  assign LINK.csr_wdata = wdata_q;
endmodule // mcm_host
`default_nettype wire

/* mcm_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mcm_assertions (
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic        csr_req,
  input wire logic        csr_we,
  input wire logic        csr_cpu,
  input wire logic [3:0]  csr_addr,
  input wire logic [63:0] csr_wdata,
  input wire logic        csr_ack,
  input wire logic [63:0] csr_rdata
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  sequence take_s;
    csr_req && !csr_ack;
  endsequence
  sequence rd_ack_s;
    csr_ack && !csr_we;
  endsequence
  ack_time_a: assert property (take_s |=> csr_ack)
    else $error("csr ack late");
  ack_once_a: assert property (csr_ack |=> !csr_ack)
    else $error("csr ack too wide");
  ack_cause_a: assert property (csr_ack |-> $past(csr_req) && !$past(csr_ack))
    else $error("csr ack without request");
  req_hold_a: assert property (take_s |=> csr_req && $stable({csr_addr, csr_wdata}))
    else $error("csr request moved before ack");
  req_drop_a: assert property (csr_ack |=> !csr_req)
    else $error("csr request held after ack");
  rdata_hold_a: assert property ($changed(csr_rdata) |-> rd_ack_s)
    else $error("csr read data moved");
  unmapped_zero_a: assert property (rd_ack_s ##0 csr_addr inside {4'h7, [4'hB:4'hF]}
    |-> csr_rdata == 64'h0)
    else $error("unmapped read not zero");
  ovf_valid_a: assert property (rd_ack_s ##0 csr_addr == 4'h5 |-> csr_rdata[63] || !csr_rdata[62])
    else $error("overflow on empty queue");
endmodule // mcm_assertions
`default_nettype wire

/* test_message_copy_mover_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_message_copy_mover_regs;
  logic        clk, rst_n, cyc, we, ack, done, purge, st;
  logic [4:0]  adr;
  logic [31:0] dw, dr;
  logic [3:0]  cls;
  logic [10:0] ecp;
  logic [21:0] rem;
  logic [22:0] bytes, lb;
  logic [63:0] v;
  logic [3:0]  sel, bs;
  logic [27:0] fr;
  logic [9:0]  sxi;
  logic [21:0] sxo;
  logic [59:0] lx;
  int          n_fail, total_checks, nst;
  mcm_if lk();
  mcm_host i_mcm_host (.CLK_SYS(clk), .RESETN(rst_n), .LINK(lk), .WB_CYC_I(cyc),
    .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw),
    .WB_DAT_O(dr), .WB_ACK_O(ack));
  mcm_device i_mcm_device (.CLK_SYS(clk), .RESETN(rst_n), .LINK(lk), .PURGE_SEEN(purge),
    .OP_START(st), .OP_MSG(), .OP_ZERO(), .OP_BYTES(bytes), .OP_SRC_FRAME(fr),
    .OP_SRC_TBL(), .OP_SRC_IDX(sxi), .OP_SRC_OFF(sxo), .OP_DST_FRAME(), .OP_DST_TBL(),
    .OP_DST_IDX(), .OP_DST_OFF(), .OP_MSG_LINE(), .OP_DONE(done), .OP_CLASS(cls),
    .OP_CTRL(ecp[10:9]), .OP_PORT(ecp[8:5]), .OP_CODE(ecp[4:0]), .OP_REMAIN(rem));
  mcm_assertions i_mcm_assertions (.CLK_SYS(clk), .RESETN(rst_n), .csr_req(lk.csr_req),
    .csr_we(lk.csr_we), .csr_cpu(lk.csr_cpu), .csr_addr(lk.csr_addr),
    .csr_wdata(lk.csr_wdata), .csr_ack(lk.csr_ack), .csr_rdata(lk.csr_rdata));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // start pulse may land while the host is still polling, so latch it;
  // blocking so a waiter woken on the same edge already sees the latch
  always @(posedge clk)
  begin
    if (st === 1'b1)
    begin
      nst++;
      lb = bytes;
      lx = {fr, sxi, sxo};
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= bs;
    // no cycle count assumed: waits for ack with no limit; only the watchdog ends a hang
    do
      @(posedge clk);
    while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask
  // one device access via the controller, processor 0 only
  task automatic csr(input logic w, input logic [3:0] a, input logic [63:0] d);
    wb(1'b1, 5'h04, d[31:0]);
    wb(1'b1, 5'h08, d[63:32]);
    wb(1'b1, 5'h00, {24'h00_0000, a, 3'h0, w});
    do wb(1'b0, 5'h00, 32'h0000_0000); while (dr[8] !== 1'b0);
    if (!w)
    begin
      wb(1'b0, 5'h0C, 32'h0000_0000);
      v[31:0] = dr;
      wb(1'b0, 5'h10, 32'h0000_0000);
      v[63:32] = dr;
    end
  endtask
  function automatic logic [63:0] ent(input logic [1:0] i, input logic o);
    return {1'b1, o, i, 2'h0, i, i, 2'h1, i, 3'h2, i, 23'h00_0000,
            i == 2'h0 ? 22'h3F_FFFF : {20'h0_0040, i}};
  endfunction
  task automatic op(input logic [1:0] sx, input logic [3:0] ab, input logic m,
                    input logic [2:0] ir, input logic [21:0] ln, input logic [22:0] nb);
    int k;
    k = nst;
    csr(1'b1, 4'h6, 64'h1);
    csr(1'b1, 4'h0, {23'h00_0000, 1'b1, sx, ab, m, 3'h0, ir, 5'h0B, ln});
    if (nb != 23'h0)
    begin
      for (int t = 0; t < 40 && nst == k; t++) @(posedge clk);
      chk("bytes", 64'(nb), 64'(lb));
      csr(1'b0, 4'h0, 64'h0);
      chk("ready", 64'h0, 64'(v[40]));
      @(posedge clk);
      done <= 1'b1;
      cls <= {2'h0, sx};
      ecp <= {sx, 2'h1, sx, 3'h2, sx};
      rem <= {20'h0_0040, sx};
      @(posedge clk);
      done <= 1'b0;
    end
  endtask
  initial
  begin
    {rst_n, cyc, we, done, purge} = 5'h00;
    {adr, dw, cls, ecp, rem} = '0;
    bs = 4'hF;
    sel = 4'hF;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    csr(1'b1, 4'h6, 64'h1);
    csr(1'b1, 4'h1, 64'h000A_BCDE_F000);
    csr(1'b1, 4'h1, 64'h0001_2345_6000);
    csr(1'b0, 4'h1, 64'h0);
    chk("src frame", 64'h000A_BCDE_F000, v);
    csr(1'b0, 4'h6, 64'h0);
    chk("context", 64'h0, v);
    csr(1'b0, 4'hF, 64'h0);
    chk("unmapped", 64'h0, v);
    wb(1'b1, 5'h04, 32'hFFFF_FFFF);
    bs = 4'h3;
    wb(1'b1, 5'h04, 32'h0000_1234);
    bs = 4'hF;
    wb(1'b0, 5'h04, 32'h0000_0000);
    chk("byte select", 64'hFFFF_1234, 64'(dr));
    $display("test gating done");
    csr(1'b1, 4'h8, 64'h3);
    csr(1'b1, 4'hA, 64'h0);
    csr(1'b1, 4'h6, 64'h1);
    csr(1'b1, 4'h3, 64'h002A_5F37);
    op(2'h0, 4'h0, 1'b0, 3'h4, 22'h00_0000, 23'h00_0001);
    chk("src plain", {28'h0AB_CDEF, 10'h000, 22'h2A_5F37}, 64'(lx));
    op(2'h1, 4'h2, 1'b0, 3'h4, 22'h00_001F, 23'h00_0020);
    chk("src table", {28'h0AB_CDEF, 10'h2A5, 22'h00_0F37}, 64'(lx));
    op(2'h2, 4'h0, 1'b1, 3'h4, 22'h00_003F, 23'h00_0040);
    op(2'h3, 4'h0, 1'b1, 3'h4, 22'h3F_FFFF, 23'h40_0000);
    for (int i = 0; i < 4; i++)
    begin
      csr(1'b0, 4'h5, 64'h0);
      chk("status", i < 3 ? ent(i[1:0], i == 0) : 64'h0, i < 3 ? v : 64'(v[63]));
    end
    csr(1'b0, 4'h9, 64'h0);
    chk("rx avail", 64'h0040_0040, v);
    wb(1'b0, 5'h14, 32'h0000_0000);
    chk("irq taken", 64'h96, 64'(dr[7:0]));
    wb(1'b1, 5'h14, 32'h0000_0080);
    @(posedge clk);
    purge <= 1'b1;
    @(posedge clk);
    purge <= 1'b0;
    csr(1'b0, 4'h0, 64'h0);
    chk("purge seen", 64'h1, 64'(v[36]));
    op(2'h3, 4'hC, 1'b0, 3'h2, 22'h00_0ABC, 23'h00_0000);
    csr(1'b0, 4'h5, 64'h0);
    chk("abort status", 64'hB100_0000_0000_0ABC, v);
    wb(1'b0, 5'h14, 32'h0000_0000);
    chk("irq done", 64'h97, 64'(dr[7:0]));
    $display("test operations done");
    print_verdict;
  end
  // whole run is well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // test_message_copy_mover_regs
`default_nettype wire
